/* File: core/pid_pkg.sv */
// Constants shared by the pin interrupt detection block.
package pid_pkg;
	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_EXT_CTRL  = 8'h88;
	localparam logic [7:0] IDX_GPI_MODE  = 8'h9A;
	localparam logic [7:0] IDX_GPI_POL   = 8'h9B;
	localparam logic [7:0] IDX_GPI_EN    = 8'h9C;
	localparam logic [7:0] IDX_GPI_FLAGS = 8'h9D;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'hA0;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'hA1;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned EXT_TRIG_LSB = 0;
	localparam int unsigned EXT_FLAG_LSB = 2;
	localparam int unsigned ST_EXT_LSB   = 0;
	localparam int unsigned ST_GPI       = 2;
	localparam int unsigned ST_W         = 3;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]      GPI_REG_RST  = 8'h00;
	localparam logic [1:0]      EXT_TRIG_RST = 2'h0;
	localparam logic [1:0]      EXT_SMP_RST  = 2'h3;
	localparam logic [ST_W-1:0] ST_RST       = 3'h0;
endpackage

/* File: core/pid_pin_irq.sv */
// Pin interrupt detection: two dedicated external lines and a port of general-purpose lines.
`timescale 1ns/1ps
// Overview of operation
// R1: Trigger type 0 raises the external request while the pin samples low.
// R2: Trigger type 1 sets the request flag on a high sample then low sample.
// R3: Each external pin is sampled once per clock; detection uses those samples.
// R4: The source holds the pin high two cycles, then low two cycles.
// R5: An edge-mode request flag clears when the processor enters its service routine.
// R6: Either external request issues a wake request.
// R7: Eight independently configured general-purpose inputs, one per port pin.
// R8: A per-pin mode bit selects level or edge detection.
// R9: Polarity 0 means low level or falling edge; 1 high or rising.
// R10: Port sampled every cycle; level needs two consecutive matching samples.
// R11: Edge mode detects a change between samples in the chosen direction.
// R12: Hardware sets a pin flag only on a detected condition with the pin enabled; a software write of 1 also sets it.
// R13: Pin flags stay set until software clears them; hardware never clears.
// R14: Any general-purpose flag issues a wake request.
// R15: Enable bit 0 disables a pin, 1 enables it.
// R16: Mode bit 0 selects level detection, 1 selects edge detection.
// R17: One combined request is high while any general-purpose flag is set.
module pid_pin_irq
	import pid_pkg::*;
#(
	parameter int unsigned GPI_W  = 8,
	parameter int unsigned ADDR_W = 10
) (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	input  wire logic              we_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	output logic                   ack_o,
	input  wire logic              ext_irq_pin_zero_i,
	input  wire logic              ext_irq_pin_one_i,
	input  wire logic [1:0]        ext_service_ack_i,
	input  wire logic [GPI_W-1:0]  port1_pin_i,
	output logic                   ext_request_flag_zero_o,
	output logic                   ext_request_flag_one_o,
	output logic                   gpi_irq_o,
	output logic                   wake_o,
	output logic                   irq_o
);
	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (GPI_W < 1 || GPI_W > 8) begin : g_bad_width
		$error("GPI_W must lie between 1 and 8");
	end
	if (ADDR_W < 10) begin : g_bad_addr
		$error("ADDR_W must be at least 10");
	end

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [1:0]       ext_trig;
	logic [1:0]       ext_smp;
	logic [1:0]       ext_prev;
	logic [1:0]       ext_flag;
	logic [1:0]       ext_set;
	logic [1:0]       ext_req;
	logic [1:0]       ext_req_q;
	logic [GPI_W-1:0] gpi_mode;
	logic [GPI_W-1:0] gpi_pol;
	logic [GPI_W-1:0] gpi_en;
	logic [GPI_W-1:0] gpi_flags;
	logic [GPI_W-1:0] p1_smp;
	logic [GPI_W-1:0] p1_prev;
	logic [GPI_W-1:0] gpi_cond;
	logic [GPI_W-1:0] gpi_set;
	logic [ST_W-1:0]  irq_stat;
	logic [ST_W-1:0]  irq_mask;
	logic [ST_W-1:0]  irq_ev;
	logic [7:0]       idx;
	logic             bus_wr;
	logic             bus_rd;
	logic [31:0]      next_dat;

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] r, input logic w);
		wr_hit = w && (a == r);
	endfunction

	function automatic logic [31:0] zext(input logic [GPI_W-1:0] v);
		zext = {{(32-GPI_W){1'b0}}, v};
	endfunction

	// ---------------------------------------------------------------
	// Wishbone slave
	// ---------------------------------------------------------------
	// The answer comes one cycle after the request; the write lands on the acked edge.
	assign idx    = adr_i[9:2];
	assign bus_rd = cyc_i && stb_i && !ack_o;
	assign bus_wr = ce_i && cyc_i && stb_i && we_i && ack_o && sel_i[0];

	always_comb begin
		unique case (idx)
			IDX_EXT_CTRL:  next_dat = {28'h0000000, ext_flag, ext_trig};
			IDX_GPI_MODE:  next_dat = zext(gpi_mode);
			IDX_GPI_POL:   next_dat = zext(gpi_pol);
			IDX_GPI_EN:    next_dat = zext(gpi_en);
			IDX_GPI_FLAGS: next_dat = zext(gpi_flags);
			IDX_IRQ_STAT:  next_dat = {29'h0000000, irq_stat};
			IDX_IRQ_MASK:  next_dat = {29'h0000000, irq_mask};
			default:       next_dat = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= bus_rd;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (ce_i && bus_rd) begin
			dat_o <= next_dat;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_trig <= EXT_TRIG_RST;
			gpi_mode <= GPI_REG_RST[GPI_W-1:0];
			gpi_pol  <= GPI_REG_RST[GPI_W-1:0];
			gpi_en   <= GPI_REG_RST[GPI_W-1:0];
			irq_mask <= ST_RST;
		end else begin
			if (wr_hit(idx, IDX_EXT_CTRL, bus_wr)) begin
				ext_trig <= dat_i[EXT_TRIG_LSB +: 2];
			end
			if (wr_hit(idx, IDX_GPI_MODE, bus_wr)) begin
				gpi_mode <= dat_i[GPI_W-1:0];
			end
			if (wr_hit(idx, IDX_GPI_POL, bus_wr)) begin
				gpi_pol <= dat_i[GPI_W-1:0];
			end
			if (wr_hit(idx, IDX_GPI_EN, bus_wr)) begin
				gpi_en <= dat_i[GPI_W-1:0];
			end
			if (wr_hit(idx, IDX_IRQ_MASK, bus_wr)) begin
				irq_mask <= dat_i[ST_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Dedicated external lines
	// ---------------------------------------------------------------
	// Samples reset high so an idle line cannot look like a falling edge.
	// R3: one sample per cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_smp  <= EXT_SMP_RST;
			ext_prev <= EXT_SMP_RST;
		end else if (ce_i) begin
			ext_smp  <= {ext_irq_pin_one_i, ext_irq_pin_zero_i};
			ext_prev <= ext_smp;
		end
	end

	// R2: high then low sample
	assign ext_set = ext_trig & ext_prev & ~ext_smp;

	// R5: service entry clears edge flag
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_flag <= 2'h0;
		end else if (ce_i) begin
			ext_flag <= ((ext_flag & ~ext_service_ack_i) | ext_set) & ext_trig;
		end
	end

	// R1: level mode follows low sample
	assign ext_req = ext_flag | (~ext_trig & ~ext_smp);
	assign ext_request_flag_zero_o = ext_req[0];
	assign ext_request_flag_one_o  = ext_req[1];

	// ---------------------------------------------------------------
	// General-purpose lines
	// ---------------------------------------------------------------
	// R10: port sampled every cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			p1_smp  <= GPI_REG_RST[GPI_W-1:0];
			p1_prev <= GPI_REG_RST[GPI_W-1:0];
		end else if (ce_i) begin
			p1_smp  <= port1_pin_i;
			p1_prev <= p1_smp;
		end
	end

	// R7: one detector per pin
	for (genvar i = 0; i < GPI_W; i++) begin : g_pin
		// R8: mode picks detector
		// R16: 0 level, 1 edge
		// R9: polarity selects direction
		// R11: change in chosen direction
		assign gpi_cond[i] = gpi_mode[i]
			? (p1_smp[i] == gpi_pol[i]) && (p1_prev[i] != gpi_pol[i])
			: (p1_smp[i] == gpi_pol[i]) && (p1_prev[i] == gpi_pol[i]);
	end

	// R12: condition and enable
	// R15: enable gates the pin
	assign gpi_set = gpi_cond & gpi_en;

	// Set wins over a software write in the same cycle, so no event is lost.
	// R13: only software clears
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			gpi_flags <= GPI_REG_RST[GPI_W-1:0];
		end else if (ce_i) begin
			if (wr_hit(idx, IDX_GPI_FLAGS, bus_wr)) begin
				gpi_flags <= dat_i[GPI_W-1:0] | gpi_set;
			end else begin
				gpi_flags <= gpi_flags | gpi_set;
			end
		end
	end

	// R17: combined request
	assign gpi_irq_o = |gpi_flags;
	// R6: external lines wake
	// R14: any pin flag wakes
	assign wake_o = (|ext_req) || (|gpi_flags);

	// ---------------------------------------------------------------
	// Interrupt status and mask
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_req_q <= 2'h0;
		end else if (ce_i) begin
			ext_req_q <= ext_req;
		end
	end

	assign irq_ev = {|gpi_set, ext_req & ~ext_req_q};

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_stat <= ST_RST;
		end else if (ce_i) begin
			if (wr_hit(idx, IDX_IRQ_STAT, bus_wr)) begin
				irq_stat <= (irq_stat & ~dat_i[ST_W-1:0]) | irq_ev;
			end else begin
				irq_stat <= irq_stat | irq_ev;
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_ext_level;
		@(posedge ref_clk_i) disable iff (rst_i)
		($past(ce_i) && !ext_trig[0] && !$past(ext_irq_pin_zero_i)) |-> ext_request_flag_zero_o;
	endproperty
	a_ext_level: assert property (p_ext_level) else $error("level request missing"); // R1

	property p_ext_edge;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && ext_trig[1] && ext_prev[1] && !ext_smp[1] && $stable(ext_trig)) ##1 ext_trig[1]
			|-> ext_request_flag_one_o;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("edge flag not set"); // R2

	property p_ext_sample;
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i |=> (ext_smp[0] == $past(ext_irq_pin_zero_i)) && (ext_prev[0] == $past(ext_smp[0]));
	endproperty
	a_ext_sample: assert property (p_ext_sample) else $error("pin sample wrong"); // R3

	property p_ext_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && ext_service_ack_i[0] && !ext_set[0]) |=> !ext_flag[0];
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("flag not cleared on service"); // R5

	property p_wake;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ext_request_flag_zero_o || ext_request_flag_one_o || gpi_irq_o) |-> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not raised"); // R6

	property p_gpi_level;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && !gpi_mode[0] && gpi_en[0] && p1_smp[0] == gpi_pol[0] && p1_prev[0] == gpi_pol[0])
			|=> gpi_flags[0];
	endproperty
	a_gpi_level: assert property (p_gpi_level) else $error("level flag not set"); // R10

	property p_gpi_edge;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && gpi_mode[0] && gpi_en[0] && p1_smp[0] == gpi_pol[0] && p1_prev[0] != gpi_pol[0])
			|=> gpi_flags[0];
	endproperty
	a_gpi_edge: assert property (p_gpi_edge) else $error("edge flag not set"); // R11

	property p_gpi_fall;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && gpi_mode[0] && !gpi_pol[0] && gpi_en[0] && p1_prev[0] && !p1_smp[0]) |=> gpi_flags[0];
	endproperty
	a_gpi_fall: assert property (p_gpi_fall) else $error("falling edge flag not set"); // R9

	property p_gpi_disabled;
		@(posedge ref_clk_i) disable iff (rst_i)
		(!gpi_en[0] && !gpi_flags[0] && !bus_wr) |=> !gpi_flags[0];
	endproperty
	a_gpi_disabled: assert property (p_gpi_disabled) else $error("disabled pin set flag"); // R12

	property p_gpi_sticky;
		@(posedge ref_clk_i) disable iff (rst_i)
		(gpi_flags[0] && !wr_hit(idx, IDX_GPI_FLAGS, bus_wr)) |=> gpi_flags[0];
	endproperty
	a_gpi_sticky: assert property (p_gpi_sticky) else $error("flag dropped by hardware"); // R13

	property p_gpi_combined;
		@(posedge ref_clk_i) disable iff (rst_i)
		gpi_irq_o == (gpi_flags != '0);
	endproperty
	a_gpi_combined: assert property (p_gpi_combined) else $error("combined request wrong"); // R17

	c_ext_edge:  cover property (@(posedge ref_clk_i) disable iff (rst_i) ext_set[0] ##1 ext_flag[0]);
	c_gpi_level: cover property (@(posedge ref_clk_i) disable iff (rst_i) !gpi_mode[0] && gpi_set[0]);
	c_gpi_edge:  cover property (@(posedge ref_clk_i) disable iff (rst_i) gpi_mode[0] && gpi_set[0]);
	c_irq:       cover property (@(posedge ref_clk_i) disable iff (rst_i) irq_o ##[1:20] !irq_o);
	c_ext_clear: cover property (@(posedge ref_clk_i) disable iff (rst_i) ext_flag[0] ##1 !ext_flag[0]);
endmodule

/* File: dv/pid_src_model.sv */
// Model of the external signal sources that drive the interrupt pins.
`timescale 1ns/1ps
module pid_src_model (
	input  wire logic       ref_clk_i,
	output logic      [1:0] ext_o,
	output logic      [7:0] port_o
);
	initial begin
		ext_o = 2'h3;
		port_o = 8'h00;
	end
	task automatic set_ext(input logic [1:0] v);
		@(posedge ref_clk_i);
		ext_o <= v;
	endtask
	task automatic set_port(input logic [7:0] v);
		@(posedge ref_clk_i);
		port_o <= v;
	endtask
	task automatic pulse(input int n);
		@(posedge ref_clk_i);
		ext_o[n] <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		ext_o[n] <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
	endtask
endmodule

/* File: dv/pid_tb.sv */
// Self-checking bench for the pin interrupt detection block.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("Error %0t: %h %h", $time, a, b); end end
module testbench;
	import pid_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        ce        = 1'b1;
	logic [9:0]  adr       = 10'h000;
	logic [31:0] dat_w     = 32'h0;
	logic [31:0] dat_r;
	logic        we        = 1'b0;
	logic [3:0]  sel       = 4'h0;
	logic        cyc       = 1'b0;
	logic        stb       = 1'b0;
	logic        ack;
	logic [1:0]  svc       = 2'h0;
	logic [1:0]  ext;
	logic [7:0]  port;
	logic        f0, f1, general_pin_interrupt, wake, irq;
	logic [31:0] rd;
	logic [3:0]  lane      = 4'hF;
	logic [7:0]  ridx [4]  = '{IDX_GPI_MODE, IDX_GPI_POL, IDX_GPI_FLAGS, IDX_GPI_EN};
	logic [7:0]  ex;
	int          fails     = 0;
	int          compares  = 0;
	int          cycles    = 0;
	int          seed;
	always #2.5 ref_clk_i = ~ref_clk_i;
	pid_src_model src (.ref_clk_i(ref_clk_i), .ext_o(ext), .port_o(port));
	pid_pin_irq uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .adr_i(adr), .dat_i(dat_w),
		.dat_o(dat_r), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
		.ext_irq_pin_zero_i(ext[0]), .ext_irq_pin_one_i(ext[1]), .ext_service_ack_i(svc),
		.port1_pin_i(port), .ext_request_flag_zero_o(f0), .ext_request_flag_one_o(f1),
		.gpi_irq_o(general_pin_interrupt), .wake_o(wake), .irq_o(irq));
	task automatic finish_test;
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// Classic single cycle; the request holds until ack is sampled high.
	task automatic wb(input logic [7:0] i, input logic w, input logic [7:0] d);
		@(posedge ref_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lane;
		adr <= {i, 2'b00};
		dat_w <= {24'h0, d};
		@(posedge ref_clk_i);
		while (ack !== 1'b1) @(posedge ref_clk_i);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	function automatic logic [7:0] exp_flags(input logic [7:0] m, p, e, o, n);
		return e & ((~m & (~(o ^ p) | ~(n ^ p))) | (m & (o ^ n) & ~(n ^ p)));
	endfunction
	// Flags seen after one port change under a given configuration.
	task automatic run_gpi(input logic [7:0] m, p, e, o, n);
		wb(IDX_GPI_EN, 1'b1, 8'h00);
		src.set_port(o);
		wb(IDX_GPI_FLAGS, 1'b1, 8'h00);
		wb(IDX_GPI_MODE, 1'b1, m);
		wb(IDX_GPI_POL, 1'b1, p);
		wb(IDX_GPI_EN, 1'b1, e);
		src.set_port(n);
		tick(5);
		ex = exp_flags(m, p, e, o, n);
		wb(IDX_GPI_FLAGS, 1'b0, 8'h00);
		`CHK(rd, {24'h0, ex})
		`CHK(general_pin_interrupt, |ex)
		`CHK(wake, |ex)
		tick(6);
		wb(IDX_GPI_FLAGS, 1'b0, 8'h00);
		`CHK(rd[7:0], ex)
	endtask
	initial begin
		seed = 32'hdc878c59;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		foreach (ridx[k]) begin
			wb(ridx[k], 1'b0, 8'h00);
			`CHK(rd, 32'h0)
			wb(ridx[k], 1'b1, 8'hA5);
			wb(ridx[k], 1'b0, 8'h00);
			`CHK(rd, 32'hA5)
		end
		wb(8'h50, 1'b0, 8'h00);
		`CHK(rd, 32'h0)
		lane = 4'h0;
		wb(IDX_GPI_MODE, 1'b1, 8'h3C);
		lane = 4'hF;
		wb(IDX_GPI_MODE, 1'b0, 8'h00);
		`CHK(rd, 32'hA5)
		// Dedicated lines: level then edge, with service clear.
		src.set_ext(2'b10);
		tick(3);
		`CHK({f0, wake}, 2'b11)
		src.set_ext(2'b11);
		tick(3);
		`CHK(f0, 1'b0)
		wb(IDX_EXT_CTRL, 1'b1, 8'h03);
		src.pulse(0);
		src.pulse(1);
		tick(1);
		`CHK({f0, f1, wake}, 3'b111)
		src.set_ext(2'b11);
		tick(3);
		wb(IDX_EXT_CTRL, 1'b0, 8'h00);
		`CHK(rd, 32'h0F)
		svc <= 2'b11;
		tick(1);
		svc <= 2'b00;
		tick(2);
		`CHK({f0, f1}, 2'b00)
		wb(IDX_EXT_CTRL, 1'b1, 8'h00);
		run_gpi(8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF);
		run_gpi(8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF);
		run_gpi(8'hFF, 8'h00, 8'h0F, 8'hFF, 8'h00);
		run_gpi(8'h00, 8'h00, 8'h0F, 8'hFF, 8'h00);
		run_gpi(8'h00, 8'hFF, 8'hF0, 8'h00, 8'h00);
		repeat (20) run_gpi(8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
			8'($random(seed)));
		// Status, mask and the level interrupt output.
		run_gpi(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		wb(IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd, 32'h7)
		wb(IDX_IRQ_STAT, 1'b1, 8'h07);
		wb(IDX_IRQ_MASK, 1'b1, 8'h04);
		`CHK(irq, 1'b0)
		wb(IDX_GPI_EN, 1'b1, 8'h01);
		tick(4);
		`CHK(irq, 1'b1)
		wb(IDX_IRQ_MASK, 1'b1, 8'h00);
		tick(1);
		`CHK(irq, 1'b0)
		wb(IDX_IRQ_MASK, 1'b1, 8'h04);
		wb(IDX_GPI_EN, 1'b1, 8'h00);
		wb(IDX_GPI_FLAGS, 1'b1, 8'h00);
		wb(IDX_IRQ_STAT, 1'b0, 8'h00);
		`CHK(rd[2], 1'b1)
		wb(IDX_IRQ_STAT, 1'b1, 8'h04);
		tick(1);
		`CHK({irq, general_pin_interrupt}, 2'b00)
		// A low clock enable freezes the samples, so a low pin is not seen until the enable returns high.
		ce <= 1'b0;
		src.set_ext(2'b10);
		tick(3);
		`CHK(f0, 1'b0)
		ce <= 1'b1;
		tick(2);
		`CHK(f0, 1'b1)
		finish_test();
	end
endmodule
